// File: core/pfc_pkg.sv
package pfc_pkg;
    // Register indices; the byte address on the bus is four times the index
    localparam logic [7:0] REF_CFG_IDX = 8'h1b;
    localparam logic [7:0] PUMP_CFG_IDX = 8'h1c;
    localparam logic [7:0] FAST_HI_IDX = 8'h1d;
    localparam logic [7:0] FAST_LO_IDX = 8'h20;
    localparam logic [7:0] FB_LOW_IDX = 8'h10;
    localparam logic [7:0] FB_MID_IDX = 8'h11;
    localparam logic [7:0] FB_HIGH_IDX = 8'h12;
    localparam logic [7:0] REF_LO_IDX = 8'h19;
    localparam logic [7:0] REF_HI_IDX = 8'h1a;
    localparam logic [7:0] STATUS_IDX = 8'h40;
    // Field positions
    localparam int DIFF_BIT = 2;
    localparam int PW_LSB = 3;
    localparam int SLIP_LSB = 5;
    localparam int POL_BIT = 5;
    localparam int TIMER_HI_LSB = 5;
    // Reset values
    localparam logic [7:0] REF_CFG_RST = 8'h08;
    localparam logic [7:0] PUMP_CFG_RST = 8'h00;
    localparam logic [7:0] FAST_HI_RST = 8'h00;
    localparam logic [7:0] FAST_LO_RST = 8'h00;
    localparam logic [17:0] FB_DIV_RST = 18'h00010;
    localparam logic [15:0] REF_DIV_RST = 16'h0001;
    // Timing: each timer step is this many comparison cycles
    localparam int TIMER_STEP = 32;
    localparam int TIMER_W = 11;
    typedef enum logic [1:0] {PFC_SLIP_OFF, PFC_SLIP_X2, PFC_SLIP_X4} pfc_slip_t;
endpackage : pfc_pkg

// File: core/pfc_fast_timer.sv
`timescale 1ns/1ns
`default_nettype none
module pfc_fast_timer #(
    parameter int W = 11,
    parameter int STEP = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic start,
    input wire logic tick,
    input wire logic [W-1:0] load_val,
    // Status
    output logic running
);
    localparam int CW = W + $clog2(STEP);
    logic [CW-1:0] remain_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            remain_r <= '0;
        end else if (start) begin
            remain_r <= {load_val, {($clog2(STEP)){1'b0}}};
        end else if (tick && remain_r != '0) begin
            remain_r <= remain_r - 1'b1;
        end
    end

    assign running = (remain_r != '0);
endmodule : pfc_fast_timer
`default_nettype wire

// File: core/pfc_ref_div.sv
`timescale 1ns/1ns
`default_nettype none
module pfc_ref_div #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Divide value, zero or one bypasses
    input wire logic [W-1:0] divide,
    // Output tick, one cycle
    output logic tick
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick <= 1'b0;
        end else if (cnt_r + 1'b1 >= divide) begin
            cnt_r <= '0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule : pfc_ref_div
`default_nettype wire

// File: core/pfc_fastlock_ctrl.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module pfc_fastlock_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Phase detector
    input wire logic ref_leads,
    input wire logic fb_leads,
    // Ramp engine
    input wire logic ramp_active,
    input wire logic ramp_segment_fast_flag,
    output logic ramp_start,
    // Dividers
    output logic [17:0] fb_divide,
    output logic [19:0] ref_divide,
    output logic ref_divider_differential,
    // Charge pump
    output logic [1:0] min_pulse_width_sel,
    output logic [4:0] pump_gain,
    output logic pump_tristate,
    output logic pump_source,
    output logic pump_sink,
    // Status
    output logic fast_active
);
    logic [7:0] ref_cfg_r;
    logic [7:0] pump_cfg_r;
    logic [7:0] fast_hi_r;
    logic [7:0] fast_lo_r;
    logic [17:0] fb_div_r;
    logic [15:0] ref_div_r;
    logic [31:0] rdata_nxt;
    logic [9:0] widx;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic fb_low_wr;
    logic ref_tick;
    logic timer_run;
    logic speedup;
    logic [10:0] timer_val;
    logic [15:0] ref_eff;
    logic [1:0] slip_eff;
    logic [1:0] pw_eff;
    logic [1:0] cnt_shift;

    function automatic logic mapped(input logic [9:0] idx);
        mapped = (idx == pfc_pkg::REF_CFG_IDX) || (idx == pfc_pkg::PUMP_CFG_IDX)
            || (idx == pfc_pkg::FAST_HI_IDX) || (idx == pfc_pkg::FAST_LO_IDX)
            || (idx == pfc_pkg::FB_LOW_IDX) || (idx == pfc_pkg::FB_MID_IDX)
            || (idx == pfc_pkg::FB_HIGH_IDX) || (idx == pfc_pkg::REF_LO_IDX)
            || (idx == pfc_pkg::REF_HI_IDX) || (idx == pfc_pkg::STATUS_IDX);
    endfunction : mapped

    // Power of two clamp for the differential counter
    function automatic logic [15:0] diff_clamp(input logic [15:0] v);
        if (v >= 16'h0010) begin
            diff_clamp = 16'h0010;
        end else if (v >= 16'h0008) begin
            diff_clamp = 16'h0008;
        end else if (v >= 16'h0004) begin
            diff_clamp = 16'h0004;
        end else begin
            diff_clamp = 16'h0002;
        end
    endfunction : diff_clamp

    assign widx = paddr[11:2];
    assign addr_ok = mapped(widx) && (paddr[1:0] == 2'b00);
    assign wr_en = psel && penable && pready && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;
    assign fb_low_wr = wr_en && (widx == pfc_pkg::FB_LOW_IDX);

    // No wait state: pready rises in the first access cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // Error flag rides with pready, so a refused write never lands
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_cfg_r <= pfc_pkg::REF_CFG_RST;
        end else if (wr_en && widx == pfc_pkg::REF_CFG_IDX) begin
            ref_cfg_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pump_cfg_r <= pfc_pkg::PUMP_CFG_RST;
        end else if (wr_en && widx == pfc_pkg::PUMP_CFG_IDX) begin
            pump_cfg_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fast_hi_r <= pfc_pkg::FAST_HI_RST;
        end else if (wr_en && widx == pfc_pkg::FAST_HI_IDX) begin
            fast_hi_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fast_lo_r <= pfc_pkg::FAST_LO_RST;
        end else if (wr_en && widx == pfc_pkg::FAST_LO_IDX) begin
            fast_lo_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fb_div_r <= pfc_pkg::FB_DIV_RST;
        end else if (wr_en) begin
            case (widx)
                pfc_pkg::FB_LOW_IDX: fb_div_r[7:0] <= pwdata[7:0];
                pfc_pkg::FB_MID_IDX: fb_div_r[15:8] <= pwdata[7:0];
                pfc_pkg::FB_HIGH_IDX: fb_div_r[17:16] <= pwdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_div_r <= pfc_pkg::REF_DIV_RST;
        end else if (wr_en) begin
            case (widx)
                pfc_pkg::REF_LO_IDX: ref_div_r[7:0] <= pwdata[7:0];
                pfc_pkg::REF_HI_IDX: ref_div_r[15:8] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (widx)
            pfc_pkg::REF_CFG_IDX: rdata_nxt[7:0] = ref_cfg_r;
            pfc_pkg::PUMP_CFG_IDX: rdata_nxt[7:0] = pump_cfg_r;
            pfc_pkg::FAST_HI_IDX: rdata_nxt[7:0] = fast_hi_r;
            pfc_pkg::FAST_LO_IDX: rdata_nxt[7:0] = fast_lo_r;
            pfc_pkg::FB_LOW_IDX: rdata_nxt[7:0] = fb_div_r[7:0];
            pfc_pkg::FB_MID_IDX: rdata_nxt[7:0] = fb_div_r[15:8];
            pfc_pkg::FB_HIGH_IDX: rdata_nxt[1:0] = fb_div_r[17:16];
            pfc_pkg::REF_LO_IDX: rdata_nxt[7:0] = ref_div_r[7:0];
            pfc_pkg::REF_HI_IDX: rdata_nxt[7:0] = ref_div_r[15:8];
            pfc_pkg::STATUS_IDX: rdata_nxt[1:0] = {speedup, timer_run};
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata_nxt;
        end
    end

    // Effective settings
    assign timer_val = {fast_hi_r[7:pfc_pkg::TIMER_HI_LSB], fast_lo_r};
    assign ref_eff = ref_cfg_r[pfc_pkg::DIFF_BIT] ? diff_clamp(ref_div_r) : ref_div_r;
    always_comb begin
        pw_eff = ref_cfg_r[pfc_pkg::PW_LSB+1:pfc_pkg::PW_LSB];
        if (pw_eff == 2'd0) begin
            pw_eff = 2'd1;
        end
        slip_eff = ref_cfg_r[pfc_pkg::SLIP_LSB+1:pfc_pkg::SLIP_LSB];
        if (slip_eff == 2'd3) begin
            slip_eff = 2'(pfc_pkg::PFC_SLIP_X4);
        end
    end

    // Timer ticks at the unscaled comparison rate, so scaling never stretches it
    pfc_ref_div #(
        .W(16)
    ) u_ref_div (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .divide(ref_eff),
        .tick(ref_tick)
    );

    pfc_fast_timer #(
        .W(pfc_pkg::TIMER_W),
        .STEP(pfc_pkg::TIMER_STEP)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(fb_low_wr),
        .tick(ref_tick),
        .load_val(timer_val),
        .running(timer_run)
    );

    assign speedup = timer_run || (ramp_active && ramp_segment_fast_flag);
    assign cnt_shift = speedup ? slip_eff : 2'd0;

    // Top bits drop if software overscales; the range is its duty
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fb_divide <= pfc_pkg::FB_DIV_RST;
        end else begin
            fb_divide <= 18'(fb_div_r << cnt_shift);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_divide <= {4'h0, pfc_pkg::REF_DIV_RST};
        end else begin
            ref_divide <= {4'h0, ref_eff} << cnt_shift;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ref_divider_differential <= pfc_pkg::REF_CFG_RST[pfc_pkg::DIFF_BIT];
            min_pulse_width_sel <= pfc_pkg::REF_CFG_RST[pfc_pkg::PW_LSB+1:pfc_pkg::PW_LSB];
        end else begin
            ref_divider_differential <= ref_cfg_r[pfc_pkg::DIFF_BIT];
            min_pulse_width_sel <= pw_eff;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fast_active <= 1'b0;
        end else begin
            fast_active <= speedup;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pump_gain <= 5'h00;
            pump_tristate <= 1'b1;
        end else if (speedup) begin
            pump_gain <= fast_hi_r[4:0];
            pump_tristate <= (fast_hi_r[4:0] == 5'h00);
        end else begin
            pump_gain <= pump_cfg_r[4:0];
            pump_tristate <= (pump_cfg_r[4:0] == 5'h00);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pump_source <= 1'b0;
            pump_sink <= 1'b0;
        end else begin
            pump_source <= pump_cfg_r[pfc_pkg::POL_BIT] ? fb_leads : ref_leads;
            pump_sink <= pump_cfg_r[pfc_pkg::POL_BIT] ? ref_leads : fb_leads;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ramp_start <= 1'b0;
        end else begin
            ramp_start <= fb_low_wr;
        end
    end
endmodule : pfc_fastlock_ctrl
`default_nettype wire

// File: tb/pfc_fastlock_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module pfc_fastlock_ctrl_asserts (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Ramp engine
    input wire logic ramp_active,
    input wire logic ramp_segment_fast_flag,
    input wire logic ramp_start,
    // Loop controls
    input wire logic [19:0] ref_divide,
    input wire logic ref_divider_differential,
    input wire logic [1:0] min_pulse_width_sel,
    input wire logic [4:0] pump_gain,
    input wire logic pump_tristate,
    input wire logic pump_source,
    input wire logic pump_sink,
    input wire logic fast_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic fbw = psel && penable && pready && pwrite && !pslverr
        && paddr == {2'h0, pfc_pkg::FB_LOW_IDX, 2'h0};
    wire logic rfl = ramp_active && ramp_segment_fast_flag;
    property p_start; fbw |=> ramp_start; endproperty
    a_start: assert property (p_start) else $error("no ramp start");
    property p_cause; ramp_start |-> $past(fbw); endproperty
    a_cause: assert property (p_cause) else $error("stray ramp start");
    property p_rise; $rose(fast_active) |-> $past(fbw, 2) || $past(rfl); endproperty
    a_rise: assert property (p_rise) else $error("speedup without cause");
    property p_ramp; rfl |=> fast_active; endproperty
    a_ramp: assert property (p_ramp) else $error("fast ramp not sped up");
    property p_hold; fbw ##2 fast_active |-> fast_active [*8]; endproperty
    a_hold: assert property (p_hold) else $error("timer ended early");
    property p_tri; pump_tristate == (pump_gain == 5'h00); endproperty
    a_tri: assert property (p_tri) else $error("tristate wrong");
    property p_pw; min_pulse_width_sel != 2'h0; endproperty
    a_pw: assert property (p_pw) else $error("reserved pulse code");
    property p_dir; !(pump_source && pump_sink); endproperty
    a_dir: assert property (p_dir) else $error("source and sink");
    property p_diff; ref_divider_differential && !fast_active
        |-> ref_divide inside {20'h2, 20'h4, 20'h8, 20'h10}; endproperty
    a_diff: assert property (p_diff) else $error("bad differential divide");
endmodule : pfc_fastlock_ctrl_asserts
bind pfc_fastlock_ctrl pfc_fastlock_ctrl_asserts u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .ramp_active(ramp_active),
    .ramp_segment_fast_flag(ramp_segment_fast_flag), .ramp_start(ramp_start),
    .ref_divide(ref_divide), .ref_divider_differential(ref_divider_differential),
    .min_pulse_width_sel(min_pulse_width_sel), .pump_gain(pump_gain),
    .pump_tristate(pump_tristate), .pump_source(pump_source), .pump_sink(pump_sink),
    .fast_active(fast_active)
);
`default_nettype wire

// File: tb/pfc_vco_model.sv
`timescale 1ns/1ns
`default_nettype none
module pfc_vco_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pump and disturbance
    input wire logic pump_source,
    input wire logic pump_sink,
    input wire logic [1:0] kick,
    // Phase detector view
    output logic ref_leads,
    output logic fb_leads
);
    // Filter and oscillator folded into one phase error; wraps, no rail
    logic signed [7:0] phase_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n)
            phase_r <= 8'sh00;
        else
            phase_r <= phase_r + 8'(kick[0]) - 8'(kick[1]) - 8'(pump_source) + 8'(pump_sink);
    end
    assign ref_leads = phase_r > 8'sh00;
    assign fb_leads = phase_r < 8'sh00;
endmodule : pfc_vco_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic core_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic ramp_active = 1'h0, ramp_segment_fast_flag = 1'h0, rl, fl;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, ref_leads, fb_leads, ramp_start, ref_divider_differential;
    logic [17:0] fb_divide;
    logic [19:0] ref_divide;
    logic [1:0] min_pulse_width_sel, kick = 2'h0;
    logic [4:0] pump_gain;
    logic pump_tristate, pump_source, pump_sink, fast_active;
    logic [32:0] expq[$];
    logic [7:0] ri[4] = '{pfc_pkg::REF_CFG_IDX, pfc_pkg::PUMP_CFG_IDX,
        pfc_pkg::FAST_HI_IDX, pfc_pkg::FAST_LO_IDX};
    logic [7:0] rv[4] = '{pfc_pkg::REF_CFG_RST, pfc_pkg::PUMP_CFG_RST,
        pfc_pkg::FAST_HI_RST, pfc_pkg::FAST_LO_RST};
    int n_fail = 0, n_checks = 0, cyc = 0, n, k, sh;
    integer seed = 32'h9e87fcd1;
    pfc_fastlock_ctrl DUT (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_leads(ref_leads), .fb_leads(fb_leads), .ramp_active(ramp_active),
        .ramp_segment_fast_flag(ramp_segment_fast_flag), .ramp_start(ramp_start),
        .fb_divide(fb_divide), .ref_divide(ref_divide),
        .ref_divider_differential(ref_divider_differential),
        .min_pulse_width_sel(min_pulse_width_sel), .pump_gain(pump_gain),
        .pump_tristate(pump_tristate), .pump_source(pump_source), .pump_sink(pump_sink),
        .fast_active(fast_active)
    );
    pfc_vco_model u_vco (
        .core_clk(core_clk), .rst_n(rst_n), .pump_source(pump_source), .pump_sink(pump_sink),
        .kick(kick), .ref_leads(ref_leads), .fb_leads(fb_leads)
    );
    initial forever #50 core_clk = ~core_clk;
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out;
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // Idle edge at the end keeps back-to-back calls from double driving psel
    task automatic apb(input logic [7:0] idx, input logic wr, input logic [7:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk);
    endtask : apb
    task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
        expq.push_back(exp);
        apb(idx, 1'h0, 8'h00);
    endtask : rd
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'h1 && !pwrite)
            chk({pslverr, prdata}, expq.pop_front(), "read");
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        chk(min_pulse_width_sel, 1, "pulse reset");
        chk(pump_tristate, 1, "tristate reset");
        foreach (ri[i]) rd(ri[i], rv[i]);
        rd(8'h3f, 33'h100000000);
        foreach (ri[i]) begin
            r = $random(seed);
            apb(ri[i], 1'h1, r[7:0]);
            rd(ri[i], r[7:0]);
        end
        for (k = 0; k < 4; k++) begin
            apb(pfc_pkg::REF_CFG_IDX, 1'h1, 8'(k << 3));
            @(negedge core_clk);
            chk(min_pulse_width_sel, (k == 0) ? 1 : k, "pulse");
            @(posedge core_clk);
        end
        apb(pfc_pkg::REF_LO_IDX, 1'h1, 8'h05);
        apb(pfc_pkg::REF_CFG_IDX, 1'h1, 8'h0c);
        @(negedge core_clk);
        chk(ref_divide, 4, "ref diff");
        chk(ref_divider_differential, 1, "diff mode");
        @(posedge core_clk);
        apb(pfc_pkg::REF_CFG_IDX, 1'h1, 8'h08);
        @(negedge core_clk);
        chk(ref_divide, 5, "ref single");
        chk(ref_divider_differential, 0, "single mode");
        @(posedge core_clk);
        apb(pfc_pkg::REF_LO_IDX, 1'h1, 8'h01);
        apb(pfc_pkg::PUMP_CFG_IDX, 1'h1, 8'h03);
        apb(pfc_pkg::FAST_HI_IDX, 1'h1, 8'h1f);
        apb(pfc_pkg::FAST_LO_IDX, 1'h1, 8'h01);
        for (k = 0; k < 4; k++) begin
            sh = (k == 3) ? 2 : k;
            apb(pfc_pkg::REF_CFG_IDX, 1'h1, 8'(8'h08 | (k << 5)));
            apb(pfc_pkg::FB_LOW_IDX, 1'h1, 8'h20);
            @(negedge core_clk);
            chk(fast_active, 1, "fast start");
            chk(pump_gain, 31, "fast gain");
            chk(fb_divide, 18'h20 << sh, "fb scaled");
            chk(ref_divide, 20'h1 << sh, "ref scaled");
            for (n = 0; fast_active === 1'h1 && n < 3000; n++) @(negedge core_clk);
            chk(n, 32, "timer length");
            chk(pump_gain, 3, "normal gain");
            chk(pump_tristate, 0, "pump on");
            chk({ref_divide, fb_divide}, {20'h1, 18'h20}, "unscaled");
            @(posedge core_clk);
        end
        apb(pfc_pkg::REF_CFG_IDX, 1'h1, 8'h08);
        apb(pfc_pkg::FB_LOW_IDX, 1'h1, 8'h20);
        repeat (20) @(posedge core_clk);
        apb(pfc_pkg::FB_LOW_IDX, 1'h1, 8'h20);
        rd(pfc_pkg::STATUS_IDX, 33'h3);
        repeat (22) @(posedge core_clk);
        @(negedge core_clk);
        chk(fast_active, 1, "restart");
        for (n = 0; fast_active === 1'h1 && n < 3000; n++) @(negedge core_clk);
        @(posedge core_clk);
        apb(pfc_pkg::FAST_LO_IDX, 1'h1, 8'h00);
        apb(pfc_pkg::FB_LOW_IDX, 1'h1, 8'h20);
        repeat (2) @(negedge core_clk);
        chk(fast_active, 0, "timer off");
        @(posedge core_clk);
        ramp_active <= 1'h1;
        for (k = 0; k < 8; k++) begin
            @(posedge core_clk);
            r = $random(seed);
            ramp_segment_fast_flag <= r[0];
            @(posedge core_clk);
            @(negedge core_clk);
            chk(fast_active, r[0], "ramp speedup");
            chk(pump_gain, r[0] ? 31 : 3, "ramp gain");
        end
        @(posedge core_clk);
        ramp_active <= 1'h0;
        for (k = 0; k < 2; k++) begin
            @(posedge core_clk);
            apb(pfc_pkg::PUMP_CFG_IDX, 1'h1, 8'(8'h03 | (k << 5)));
            @(negedge core_clk);
            repeat (16) begin
                rl = ref_leads;
                fl = fb_leads;
                @(posedge core_clk);
                kick <= 2'($random(seed));
                @(negedge core_clk);
                chk({pump_source, pump_sink}, k ? {fl, rl} : {rl, fl}, "pump dir");
            end
        end
        close_out();
    end
endmodule : testbench
`default_nettype wire
